// *** hw/rfte_defs.svh ***
// Constants of the ASCII telegram engine: offsets, field positions, codes, timing.
// Assumes a 125 MHz clock and a byte-wide serial front end outside this block.
`ifndef RFTE_DEFS_SVH
`define RFTE_DEFS_SVH
// Control characters
`define RFTE_ETX 8'h03
`define RFTE_CR 8'h0d
`define RFTE_LF 8'h0a
// Status characters
`define RFTE_ST_OK 8'h30
`define RFTE_ST_BUSY 8'h31
`define RFTE_ST_PON 8'h32
`define RFTE_ST_BAD 8'h34
`define RFTE_ST_NOTAG 8'h35
// Register offsets (byte addresses)
`define RFTE_REG_CFGA 4'h0
`define RFTE_REG_CFGB 4'h4
`define RFTE_REG_STAT 4'h8
// Write fields of the first configuration register
`define RFTE_A_TRIG 7:0
`define RFTE_A_STORE 15:8
`define RFTE_A_BAUD 18:16
`define RFTE_A_TMO 25:19
`define RFTE_A_MUX 26
`define RFTE_A_PW 27
`define RFTE_A_SMALL 28
// Write fields of the second configuration register
`define RFTE_B_FIXLEN 15:0
`define RFTE_B_IDLEN 23:16
`define RFTE_B_CONF 31:24
// Limits and layout of a telegram
`define RFTE_BUF_DEPTH 160
`define RFTE_WMAX 6'h20
`define RFTE_WMAX_SMALL 6'h1d
`define RFTE_TMO_MAX 7'h64
`define RFTE_LW_DATA 8'h09
`define RFTE_P_DATA 8'h08
`define RFTE_KEY_CHARS 16'h000c
// Reset values
`define RFTE_RST_BAUD 3'h2
`define RFTE_RST_IDLEN 8'h08
// Timing
`define RFTE_CLK_MHZ 125
`define RFTE_TMO_STEP_MS 100
`define RFTE_TMO_STEP_CYC (`RFTE_TMO_STEP_MS * `RFTE_CLK_MHZ * 1000)
// Baud divisors for 2400, 4800, 9600, 19200, 38400 bit/s
`define RFTE_DIV0 17'd52083
`define RFTE_DIV1 17'd26042
`define RFTE_DIV2 17'd13021
`define RFTE_DIV3 17'd6510
`define RFTE_DIV4 17'd3255
`endif

// *** hw/rfte_pkg.sv ***
// Types shared by the telegram engine and its head-side partner.
// Assumes nothing beyond the constants header.
package rfte_pkg;
  typedef enum logic [1:0] {RFTE_OP_NONE, RFTE_OP_LOCKWR, RFTE_OP_PREAD, RFTE_OP_PWRITE} rfte_op_t;
  typedef struct packed {
    rfte_op_t op;
    logic [2:0] chan;
    logic [15:0] addr;
    logic [5:0] cnt;
    logic [15:0] lock_last;
    logic [7:0] family;
    logic [15:0] kind;
    logic [47:0] key;
  } rfte_hreq_t;
  typedef struct packed {
    logic ok;
    logic [7:0] status;
    logic [47:0] key;
  } rfte_hrsp_t;
endpackage

// *** hw/rfte_engine.sv ***
// What this block does
// - Locked-write command retries writing the counted words until one write succeeds.
// - Lock request covers only blocks from start word to last written word.
// - After success, answer, then watch the carrier; restart on leave or new carrier.
// - Status 5 only when carrier leaves or none yet, never between back-to-back tags.
// - Parameter read takes channel, family, kind, binary length, data; answers with data only for the key read.
// - Parameter write takes same fields; answers status, channel, checksum, end only.
// - Family Q with the access key selector reads or loads a twelve-hex-character head key.
// - Checksum is the modulo-256 sum of all preceding characters.
// - End of text is 3, carriage return 13, line feed 10.
// - Data field carries four bytes per word, most significant byte first.
// - Channel is one character, 1 to 4, or x for all channels.
// - Start word is four hex characters, 0000 to FFFF.
// - Word count is two hex characters up to 20, or 1D for small tags.
// - Timeout of 0 to 100 steps of 100 ms sends an error; zero disables.
// - Trigger character 0 off, 1 on, 2 inverted.
// - Store character 0 off, 1 on.
// - Read-only code length is two hex characters giving bytes.
// - Identifier length is 04h or 08h characters.
// - Status 0 for done without error, 1 while still processing.
// - Status codes 2,4,5,6,7,9,A,E for reset, bad command, no carrier, faults.
// - Baud rate selects 2400, 4800, 9600, 19200 or 38400 bit/s.
// - Configuration word character 1 selects protection, 2 selects control word.
// - Multiplex and password flags are single bits, 1 meaning on.
//
// File holds the whole engine: telegram parser, checker, head sequencer, responder.
// Assumes a byte-wide receiver and transmitter outside, and a head controller that
// answers each request with a one-cycle ack.
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`include "rfte_defs.svh"
module rfte_engine #(
  parameter int TMO_STEP_CYC = `RFTE_TMO_STEP_CYC
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output rfte_pkg::rfte_hreq_t hd_req,
  output logic hd_req_valid,
  input wire logic hd_ack,
  input wire rfte_pkg::rfte_hrsp_t hd_rsp,
  input wire logic [7:0] hd_buf_idx,
  output logic [7:0] hd_buf_byte,
  input wire logic tag_present,
  input wire logic tag_new,
  output logic [16:0] baud_div,
  output logic [1:0] trig_mode,
  output logic cfg_store,
  output logic mux_mode,
  output logic pw_mode,
  output logic [7:0] fix_len,
  output logic [7:0] id_len,
  output logic [1:0] conf_word
);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [4:0] hexv(input logic [7:0] c);
    hexv = 5'h00;
    if (c >= 8'h30 && c <= 8'h39) hexv = {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) hexv = {1'b1, c[3:0] + 4'h9};
  endfunction
  function automatic logic [7:0] hexc(input logic [3:0] n);
    hexc = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
  endfunction

  typedef enum {S_BOOT, S_IDLE, S_CHECK, S_HEAD, S_ELW, S_ELR, S_TX} rfte_state_t;
  rfte_state_t state_r, ret_r;
  logic [7:0] buf_r [0:`RFTE_BUF_DEPTH-1];
  logic [7:0] n_r, sum_r, prev_r;
  logic rdy_r, ck_ok_r, ovf_r, tmo_r;
  logic [6:0] tmo_steps_r, tmo_n_r;
  logic [31:0] tmo_cyc_r;
  logic [7:0] obuf_r [0:13];
  logic [3:0] olen_r, oidx_r;
  logic [7:0] osum_r;
  logic tx_chk_r, tx_etx_r, sent5_r, pend_r;
  logic [7:0] last_st_r, ch_r;
  logic small_r, cfg_err_r;
  logic [2:0] baud_r;
  wire rx_take = rx_valid & rx_ready;

  // ****************************************
  // Telegram reception
  // ****************************************
  // Limitation: a checksum byte equal to 03h ends the telegram early and fails the check.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      n_r <= 8'h00;
      sum_r <= 8'h00;
      prev_r <= 8'h00;
      rdy_r <= 1'b0;
      ck_ok_r <= 1'b0;
      ovf_r <= 1'b0;
      tmo_r <= 1'b0;
    end else if (rdy_r) begin
      if (state_r == S_CHECK) begin
        rdy_r <= 1'b0;
        n_r <= 8'h00;
        sum_r <= 8'h00;
        ovf_r <= 1'b0;
        tmo_r <= 1'b0;
      end
    end else if (n_r != 8'h00 && tmo_steps_r != 7'h00 && tmo_n_r >= tmo_steps_r) begin
      rdy_r <= 1'b1;
      tmo_r <= 1'b1;
    end else if (rx_take) begin
      if (rx_data == `RFTE_ETX && n_r != 8'h00) begin
        rdy_r <= 1'b1;
        ck_ok_r <= (sum_r - prev_r) == prev_r;
      end else if (!(n_r == 8'h00 && (rx_data == `RFTE_CR || rx_data == `RFTE_LF ||
                                      rx_data == `RFTE_ETX))) begin
        if (n_r == 8'(`RFTE_BUF_DEPTH)) ovf_r <= 1'b1;
        else n_r <= n_r + 8'h01;
        sum_r <= sum_r + rx_data;
        prev_r <= rx_data;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rx_take && !rdy_r && n_r < 8'(`RFTE_BUF_DEPTH)) buf_r[n_r] <= rx_data;
  end

  always_ff @(posedge ref_clk) begin
    if (srst || rx_take || n_r == 8'h00) begin
      tmo_cyc_r <= 32'h0;
      tmo_n_r <= 7'h00;
    end else if (tmo_cyc_r == 32'(TMO_STEP_CYC - 1)) begin
      tmo_cyc_r <= 32'h0;
      if (tmo_n_r != 7'h7f) tmo_n_r <= tmo_n_r + 7'h01;
    end else begin
      tmo_cyc_r <= tmo_cyc_r + 32'h1;
    end
  end

  // ****************************************
  // Telegram check
  // ****************************************
  logic [4:0] a0, a1, a2, a3, c0, c1, kv;
  logic [5:0] cnt;
  logic [7:0] body;
  logic [15:0] plen;
  logic ch_ok, is_lw, is_pr, is_wp, is_key, lw_ok, p_ok, key_ok;
  logic [47:0] key_bin;
  always_comb begin
    a0 = hexv(buf_r[3]);
    a1 = hexv(buf_r[4]);
    a2 = hexv(buf_r[5]);
    a3 = hexv(buf_r[6]);
    c0 = hexv(buf_r[7]);
    c1 = hexv(buf_r[8]);
    cnt = {c0[1:0], c1[3:0]};
    body = n_r - 8'h01;
    plen = {buf_r[6], buf_r[7]};
    ch_ok = (buf_r[2] >= 8'h31 && buf_r[2] <= 8'h34) || buf_r[2] == 8'h78;
    is_lw = buf_r[0] == 8'h45 && buf_r[1] == 8'h4c;
    is_pr = buf_r[0] == 8'h52 && buf_r[1] == 8'h50;
    is_wp = buf_r[0] == 8'h57 && buf_r[1] == 8'h50;
    // start word, count, four bytes per word
    lw_ok = a0[4] && a1[4] && a2[4] && a3[4] && c0[4] && c1[4] && c0[3:2] == 2'b00 &&
            cnt <= (small_r ? `RFTE_WMAX_SMALL : `RFTE_WMAX) &&
            body == `RFTE_LW_DATA + {cnt, 2'b00};
    p_ok = plen[15:8] == 8'h00 && body == `RFTE_P_DATA + plen[7:0];
    is_key = buf_r[3] == 8'h51 && buf_r[4] == 8'h4b && buf_r[5] == 8'h31;
    key_ok = 1'b1;
    key_bin = 48'h0;
    kv = 5'h00;
    for (int i = 0; i < 12; i++) begin
      kv = hexv(buf_r[8 + i]);
      key_ok = key_ok & kv[4];
      key_bin = {key_bin[43:0], kv[3:0]};
    end
    // A key read carries no key text, so only a write is held to it
    key_ok = !is_wp || (key_ok && plen == `RFTE_KEY_CHARS);
  end

  // ****************************************
  // Sequencer
  // ****************************************
  logic ok_cmd;
  assign ok_cmd = ck_ok_r && !ovf_r && !tmo_r && n_r >= 8'h04 && ch_ok &&
                  ((is_lw && lw_ok) || ((is_pr || is_wp) && p_ok && (!is_key || key_ok)));

  task automatic answer(input logic [7:0] st, input rfte_state_t ret);
    obuf_r[0] <= st;
    obuf_r[1] <= ch_r;
    olen_r <= 4'h2;
    ret_r <= ret;
    last_st_r <= st;
    state_r <= S_TX;
  endtask

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= S_BOOT;
      ret_r <= S_IDLE;
      hd_req_valid <= 1'b0;
      hd_req <= '0;
      pend_r <= 1'b0;
      sent5_r <= 1'b0;
      ch_r <= 8'h78;
      last_st_r <= `RFTE_ST_PON;
      olen_r <= 4'h0;
    end else begin
      hd_req_valid <= 1'b0;
      unique case (state_r)
        S_BOOT: answer(`RFTE_ST_PON, S_IDLE);
        S_IDLE: if (rdy_r) state_r <= S_CHECK;
        S_CHECK: begin
          ch_r <= ch_ok ? buf_r[2] : 8'h78;
          hd_req.chan <= (buf_r[2] == 8'h78) ? 3'h4 : buf_r[2][2:0] - 3'h1;
          hd_req.addr <= {a0[3:0], a1[3:0], a2[3:0], a3[3:0]};
          hd_req.cnt <= cnt;
          hd_req.lock_last <= {a0[3:0], a1[3:0], a2[3:0], a3[3:0]} + 16'(cnt) - 16'h1;
          hd_req.family <= buf_r[3];
          hd_req.kind <= {buf_r[4], buf_r[5]};
          hd_req.key <= key_bin;
          sent5_r <= 1'b0;
          if (!ok_cmd) begin
            obuf_r[0] <= `RFTE_ST_BAD;
            obuf_r[1] <= ch_ok ? buf_r[2] : 8'h78;
            olen_r <= 4'h2;
            last_st_r <= `RFTE_ST_BAD;
            ret_r <= S_IDLE;
            state_r <= S_TX;
          end else if (is_lw) begin
            hd_req.op <= rfte_pkg::RFTE_OP_LOCKWR;
            state_r <= S_ELW;
          end else begin
            hd_req.op <= is_pr ? rfte_pkg::RFTE_OP_PREAD : rfte_pkg::RFTE_OP_PWRITE;
            hd_req_valid <= 1'b1;
            state_r <= S_HEAD;
          end
        end
        S_HEAD: if (hd_ack) begin
          answer(hd_rsp.ok ? `RFTE_ST_OK : hd_rsp.status, S_IDLE);
          if (hd_rsp.ok && hd_req.op == rfte_pkg::RFTE_OP_PREAD
              && hd_req.family == 8'h51 && hd_req.kind == 16'h4b31) begin
            for (int i = 0; i < 12; i++) obuf_r[2 + i] <= hexc(hd_rsp.key[47 - 4*i -: 4]);
            olen_r <= 4'he;
          end
        end
        S_ELW: begin
          if (!pend_r) begin
            hd_req_valid <= 1'b1;
            pend_r <= 1'b1;
          end else if (hd_ack) begin
            pend_r <= 1'b0;
            if (hd_rsp.ok) begin
              sent5_r <= 1'b0;
              answer(`RFTE_ST_OK, S_ELR);
            end else if (hd_rsp.status == `RFTE_ST_NOTAG && !sent5_r) begin
              sent5_r <= 1'b1;
              answer(`RFTE_ST_NOTAG, S_ELW);
            end
          end
        end
        S_ELR: begin
          if (rdy_r) state_r <= S_CHECK;
          else if (n_r == 8'h00) begin
            if (!tag_present) begin
              sent5_r <= 1'b1;
              answer(`RFTE_ST_NOTAG, S_ELW);
            end else if (tag_new) state_r <= S_ELW;
          end
        end
        S_TX: if (tx_etx_r && tx_valid && tx_ready) state_r <= ret_r;
      endcase
    end
  end

  // ****************************************
  // Response transmitter
  // ****************************************
  // response checksum
  always_ff @(posedge ref_clk) begin
    if (srst || state_r != S_TX) begin
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      oidx_r <= 4'h0;
      osum_r <= 8'h00;
      tx_chk_r <= 1'b0;
      tx_etx_r <= 1'b0;
    end else if (!tx_valid || tx_ready) begin
      if (tx_etx_r) begin
        tx_valid <= 1'b0;
      end else if (tx_chk_r) begin
        tx_valid <= 1'b1;
        tx_data <= `RFTE_ETX;
        tx_etx_r <= 1'b1;
      end else if (oidx_r == olen_r) begin
        tx_valid <= 1'b1;
        tx_data <= osum_r;
        tx_chk_r <= 1'b1;
      end else begin
        tx_valid <= 1'b1;
        tx_data <= obuf_r[oidx_r];
        osum_r <= osum_r + obuf_r[oidx_r];
        oidx_r <= oidx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) rx_ready <= 1'b0;
    else rx_ready <= (state_r == S_IDLE || state_r == S_ELR) && !rdy_r &&
                     !(rx_take && rx_data == `RFTE_ETX && n_r != 8'h00);
  end

  // word data handed to the head in arrival order
  always_ff @(posedge ref_clk) begin
    hd_buf_byte <= buf_r[8'(hd_buf_idx + `RFTE_LW_DATA)];
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [4:0] f0, f1;
  assign f0 = hexv(reg_wdata[15:8]);
  assign f1 = hexv(reg_wdata[7:0]);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      trig_mode <= 2'h0;
      cfg_store <= 1'b0;
      baud_r <= `RFTE_RST_BAUD;
      tmo_steps_r <= 7'h00;
      mux_mode <= 1'b0;
      pw_mode <= 1'b0;
      small_r <= 1'b0;
      fix_len <= 8'h00;
      id_len <= `RFTE_RST_IDLEN;
      conf_word <= 2'h0;
      cfg_err_r <= 1'b0;
    end else if (reg_we && reg_addr == `RFTE_REG_CFGA) begin
      if (reg_wdata[`RFTE_A_TRIG] >= 8'h30 && reg_wdata[`RFTE_A_TRIG] <= 8'h32)
        trig_mode <= reg_wdata[1:0];
      if (reg_wdata[`RFTE_A_STORE] == 8'h30 || reg_wdata[`RFTE_A_STORE] == 8'h31)
        cfg_store <= reg_wdata[8];
      if (reg_wdata[`RFTE_A_BAUD] <= 3'h4) baud_r <= reg_wdata[`RFTE_A_BAUD];
      if (reg_wdata[`RFTE_A_TMO] <= `RFTE_TMO_MAX) tmo_steps_r <= reg_wdata[`RFTE_A_TMO];
      mux_mode <= reg_wdata[`RFTE_A_MUX];
      pw_mode <= reg_wdata[`RFTE_A_PW];
      small_r <= reg_wdata[`RFTE_A_SMALL];
      cfg_err_r <= reg_wdata[`RFTE_A_TRIG] < 8'h30 || reg_wdata[`RFTE_A_TRIG] > 8'h32 ||
                   reg_wdata[15:9] != 7'h18 || reg_wdata[`RFTE_A_BAUD] > 3'h4 ||
                   reg_wdata[`RFTE_A_TMO] > `RFTE_TMO_MAX;
    end else if (reg_we && reg_addr == `RFTE_REG_CFGB) begin
      if (f0[4] && f1[4]) fix_len <= {f0[3:0], f1[3:0]};
      if (reg_wdata[`RFTE_B_IDLEN] == 8'h04 || reg_wdata[`RFTE_B_IDLEN] == 8'h08)
        id_len <= reg_wdata[`RFTE_B_IDLEN];
      if (reg_wdata[`RFTE_B_CONF] == 8'h31 || reg_wdata[`RFTE_B_CONF] == 8'h32)
        conf_word <= reg_wdata[25:24];
      cfg_err_r <= !(f0[4] && f1[4]) ||
                   !(reg_wdata[`RFTE_B_IDLEN] == 8'h04 || reg_wdata[`RFTE_B_IDLEN] == 8'h08) ||
                   !(reg_wdata[`RFTE_B_CONF] == 8'h31 || reg_wdata[`RFTE_B_CONF] == 8'h32);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) baud_div <= `RFTE_DIV2;
    else begin
      unique case (baud_r)
        3'h0: baud_div <= `RFTE_DIV0;
        3'h1: baud_div <= `RFTE_DIV1;
        3'h2: baud_div <= `RFTE_DIV2;
        3'h3: baud_div <= `RFTE_DIV3;
        default: baud_div <= `RFTE_DIV4;
      endcase
    end
  end

  // ****************************************
  // Register read
  // ****************************************
  logic busy;
  assign busy = state_r == S_CHECK || state_r == S_HEAD || state_r == S_ELW;
  always_ff @(posedge ref_clk) begin
    if (srst || !reg_re) reg_rdata <= 32'h0;
    else begin
      unique case (reg_addr)
        `RFTE_REG_CFGA: reg_rdata <= {15'h0, cfg_err_r, small_r, pw_mode, mux_mode, tmo_steps_r,
                                      baud_r, cfg_store, trig_mode};
        `RFTE_REG_CFGB: reg_rdata <= {14'h0, conf_word, id_len, fix_len};
        `RFTE_REG_STAT: reg_rdata <= {22'h0, state_r == S_ELR || state_r == S_ELW, busy,
                                      busy ? `RFTE_ST_BUSY : last_st_r};
        default: reg_rdata <= 32'h0;
      endcase
    end
  end
endmodule // rfte_engine

// *** sim/rfte_engine_asserts.sv ***
// Port-level checker for the telegram engine.
// Assumes the engine's ports and constants header; bound at the foot.
`timescale 1ns/10ps
`include "rfte_defs.svh"
module rfte_engine_asserts (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire rfte_pkg::rfte_hreq_t hd_req,
  input wire logic hd_req_valid,
  input wire logic hd_ack,
  input wire rfte_pkg::rfte_hrsp_t hd_rsp,
  input wire logic [16:0] baud_div,
  input wire logic [1:0] trig_mode,
  input wire logic [1:0] conf_word
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);
  logic lkw;
  assign lkw = hd_req.op == rfte_pkg::RFTE_OP_LOCKWR;
  // ****
  // Assertions
  // ****
  // silent retry
  a_retry_fail: assert property (
    hd_ack && lkw && !hd_rsp.ok && hd_rsp.status != `RFTE_ST_NOTAG |-> ##[1:200] hd_req_valid)
    else $error("failed locked write not retried");
  a_lock_span: assert property (
    hd_req_valid && lkw && hd_req.cnt != 6'h00
    |-> hd_req.lock_last == hd_req.addr + 16'(hd_req.cnt) - 16'h0001)
    else $error("lock span differs from written words");
  a_req_pulse: assert property (hd_req_valid |=> !hd_req_valid)
    else $error("request pulse longer than one cycle");
  a_rx_shut: assert property (hd_req_valid |-> !rx_ready)
    else $error("serial input open during attempt");
  a_chan_code: assert property (hd_req_valid |-> hd_req.chan <= 3'h4)
    else $error("channel out of range");
  a_cnt_limit: assert property (hd_req_valid && lkw |-> hd_req.cnt <= 6'h20)
    else $error("word count above limit");
  a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("response byte dropped while stalled");
  a_trig_code: assert property (trig_mode != 2'h3)
    else $error("illegal trigger mode");
  a_baud_set: assert property (baud_div inside {`RFTE_DIV0, `RFTE_DIV1,
    `RFTE_DIV2, `RFTE_DIV3, `RFTE_DIV4}) else $error("baud divisor not in set");
  a_conf_word: assert property (conf_word != 2'h3)
    else $error("illegal configuration word");
  c_lock_req: cover property (hd_req_valid && lkw);
  c_fail_ack: cover property (hd_ack && !hd_rsp.ok);
  c_notag_tx: cover property (tx_valid && tx_ready && tx_data == `RFTE_ST_NOTAG);
endmodule // rfte_engine_asserts

bind rfte_engine rfte_engine_asserts i_chk (.ref_clk(ref_clk), .srst(srst),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
  .hd_req(hd_req), .hd_req_valid(hd_req_valid), .hd_ack(hd_ack), .hd_rsp(hd_rsp),
  .baud_div(baud_div), .trig_mode(trig_mode), .conf_word(conf_word));

// *** sim/rfte_head_model.sv ***
// Behavioural head controller on the engine's head port.
// Assumes one outstanding request; bench sets key, fault count and delay.
`timescale 1ns/10ps
`include "rfte_defs.svh"
module rfte_head_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire rfte_pkg::rfte_hreq_t hd_req,
  input wire logic hd_req_valid,
  output logic hd_ack,
  output rfte_pkg::rfte_hrsp_t hd_rsp,
  output logic [7:0] hd_buf_idx,
  input wire logic [7:0] hd_buf_byte,
  input wire logic tag_present,
  input wire logic [47:0] key_val,
  input wire logic [3:0] fail_n,
  input wire logic [3:0] dly
);
  logic [7:0] got [0:3];
  int fails = 0;
  // ****
  // Request service
  // ****
  task automatic serve();
    int n;
    n = (hd_req.op == rfte_pkg::RFTE_OP_LOCKWR) ? 4 * int'(hd_req.cnt) : 0;
    for (int i = 0; i < n; i++) begin
      hd_buf_idx <= 8'(i);
      @(posedge ref_clk);
      @(negedge ref_clk);
      if (i < 4) got[i] = hd_buf_byte;
      @(posedge ref_clk);
    end
    repeat (dly) @(posedge ref_clk);
    hd_ack <= 1'b1;
    hd_rsp.key <= key_val;
    hd_rsp.ok <= 1'b0;
    if (!tag_present) begin
      hd_rsp.status <= `RFTE_ST_NOTAG;
    end else if (fails < int'(fail_n)) begin
      hd_rsp.status <= 8'h36;
      fails++;
    end else begin
      hd_rsp.ok <= 1'b1;
      fails = 0;
    end
    @(posedge ref_clk);
    hd_ack <= 1'b0;
    hd_rsp <= ~hd_rsp;
  endtask

  initial begin
    hd_ack = 1'b0;
    hd_rsp = '0;
    hd_buf_idx = 8'h00;
    forever begin
      @(posedge ref_clk);
      if (hd_req_valid && !srst) serve();
    end
  end
endmodule // rfte_head_model

// *** sim/rfte_engine_test.sv ***
// Self-checking bench for the telegram engine: host side driven here.
// Assumes the head model beside it and the bound port checker.
`timescale 1ns/10ps
`include "rfte_defs.svh"
module rfte_engine_test;
  typedef logic [7:0] rfte_bq_t[$];
  logic ref_clk = 1'b0, srst = 1'b1, reg_we, reg_re, rx_valid, rx_ready, tx_valid, tx_ready;
  logic [3:0] reg_addr, fail_n, dly;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [7:0] rx_data, tx_data, hd_buf_idx, hd_buf_byte, fix_len, id_len;
  logic hd_req_valid, hd_ack, tag_present, tag_new, cfg_store, mux_mode, pw_mode;
  logic [16:0] baud_div;
  logic [16:0] divs [5] = '{`RFTE_DIV0, `RFTE_DIV1, `RFTE_DIV2, `RFTE_DIV3, `RFTE_DIV4};
  logic [1:0] trig_mode, conf_word;
  logic [47:0] key_val;
  rfte_pkg::rfte_hreq_t hd_req, last_req;
  rfte_pkg::rfte_hrsp_t hd_rsp;
  rfte_bq_t exp_q;
  logic [31:0] rd_q[$];
  logic re_d = 1'b0;
  int miscompares = 0, checks = 0, cyc = 0, nreq = 0, n0;

  rfte_engine #(.TMO_STEP_CYC(10)) i_dut (.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_we,
    .reg_re, .reg_rdata, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready,
    .hd_req, .hd_req_valid, .hd_ack, .hd_rsp, .hd_buf_idx, .hd_buf_byte, .tag_present,
    .tag_new, .baud_div, .trig_mode, .cfg_store, .mux_mode, .pw_mode, .fix_len, .id_len,
    .conf_word);
  rfte_head_model i_head (.ref_clk, .srst, .hd_req, .hd_req_valid, .hd_ack, .hd_rsp,
    .hd_buf_idx, .hd_buf_byte, .tag_present, .key_val, .fail_n, .dly);

  always #4 ref_clk = ~ref_clk;
  // ****
  // Helpers
  // ****
  task automatic check(logic [63:0] got, logic [63:0] exp, string m);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, m, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic rfte_bq_t sq(string s);
    rfte_bq_t q;
    foreach (s[i]) q.push_back(8'(s[i]));
    return q;
  endfunction
  function automatic logic [7:0] sum8(rfte_bq_t q);
    logic [7:0] s;
    s = 8'h00;
    foreach (q[i]) s += q[i];
    return s;
  endfunction
  function automatic rfte_bq_t hexq(logic [47:0] k);
    rfte_bq_t q;
    logic [7:0] n;
    for (int i = 11; i >= 0; i--) begin
      n = 8'(k[i*4+:4]);
      q.push_back(n < 8'h0a ? 8'h30 + n : 8'h37 + n);
    end
    return q;
  endfunction
  task automatic expect_rsp(rfte_bq_t q);
    exp_q = {exp_q, q, sum8(q), `RFTE_ETX};
  endtask
  // Waits on the taking edge; the watchdog bounds a stuck input
  task automatic send(rfte_bq_t q, logic [7:0] bad, bit full);
    if (full) q = {q, sum8(q) + bad, `RFTE_ETX};
    foreach (q[i]) begin
      rx_valid <= 1'b1;
      rx_data <= q[i];
      do @(posedge ref_clk); while (!rx_ready);
    end
    rx_valid <= 1'b0;
  endtask
  task automatic acc(bit w, logic [3:0] a, logic [31:0] v);
    reg_we <= w;
    reg_re <= !w;
    reg_addr <= a;
    reg_wdata <= v;
    if (!w) rd_q.push_back(v);
    @(posedge ref_clk);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic drain();
    repeat (3) @(posedge ref_clk);
    while (exp_q.size() != 0) @(posedge ref_clk);
    repeat (30) @(posedge ref_clk);
    $display("test done at %0t", $time);
  endtask
  // ****
  // Output watcher
  // ****
  always @(posedge ref_clk) begin
    re_d <= reg_re;
    if (re_d) check(reg_rdata, rd_q.pop_front(), "register read");
    if (tx_valid && tx_ready) check(tx_data, exp_q.pop_front(), "response byte");
    if (hd_req_valid) begin
      last_req <= hd_req;
      nreq <= nreq + 1;
    end
    tx_ready <= $urandom_range(3) != 0;
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    {reg_we, reg_re, rx_valid, tx_ready, tag_present, tag_new} = '0;
    {reg_addr, reg_wdata, rx_data, key_val, fail_n, dly} = '0;
    d = $urandom(90);
    expect_rsp(sq("2x"));
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    acc(0, `RFTE_REG_CFGA, 32'h0000_0010);
    acc(0, `RFTE_REG_CFGB, 32'h0000_0800);
    for (int t = 0; t < 3; t++) begin
      for (int b = 0; b < 5; b++) begin
        acc(1, `RFTE_REG_CFGA, {4'h0, !1'(t), 1'(t), 7'h00, 3'(b), 8'h30 + 8'(t % 2),
          8'h30 + 8'(t)});
        acc(0, `RFTE_REG_CFGA, {17'h0, !1'(t), 1'(t), 7'h00, 3'(b), 1'(t), 2'(t)});
        check(baud_div, divs[b], "baud");
        check({trig_mode, cfg_store}, {2'(t), 1'(t)}, "trigger store");
        check({mux_mode, pw_mode}, {1'(t), !1'(t)}, "mode bits");
      end
    end
    acc(1, `RFTE_REG_CFGA, {3'h0, 3'b101, 7'h00, 3'h2, 8'h31, 8'h33});
    acc(1, 4'hc, 32'hffff_ffff);
    acc(0, `RFTE_REG_CFGA, {15'h0, 4'b1101, 7'h00, 3'h2, 3'b110});
    acc(0, 4'hc, 32'h0);
    for (int c = 1; c < 3; c++) begin
      acc(1, `RFTE_REG_CFGB, {8'h30 + 8'(c), 8'h04, 8'h31, 8'h31});
      check({fix_len, id_len, conf_word}, {8'h11, 8'h04, 2'(c)}, "cfgb");
      acc(0, `RFTE_REG_CFGB, {14'h0, 2'(c), 8'h04, 8'h11});
    end
    drain();
    expect_rsp(sq("41"));
    send(sq("EL100001E"), 8'h00, 1);
    drain();
    tag_present <= 1'b1;
    dly = 4'h5;
    key_val = {$urandom, 16'($urandom)};
    expect_rsp({sq("03"), hexq(key_val)});
    send({sq("RP3QK1"), 8'h00, 8'h00}, 8'h00, 1);
    drain();
    check({last_req.op, last_req.chan, last_req.family, last_req.kind},
      {rfte_pkg::RFTE_OP_PREAD, 3'h2, 8'h51, 16'h4b31}, "key read request");
    key_val = ~key_val;
    while (sum8({sq("WPxQK1"), 8'h00, 8'h0c, hexq(key_val)}) == 8'h03) key_val++;
    expect_rsp(sq("0x"));
    send({sq("WPxQK1"), 8'h00, 8'h0c, hexq(key_val)}, 8'h00, 1);
    drain();
    check({last_req.op, last_req.chan, last_req.key},
      {rfte_pkg::RFTE_OP_PWRITE, 3'h4, key_val}, "key write request");
    tag_present <= 1'b0;
    n0 = nreq;
    expect_rsp(sq("41"));
    send({sq("RP1QK1"), 8'h00, 8'h00}, 8'h01, 1);
    drain();
    expect_rsp(sq("41"));
    send(sq("ZZ1"), 8'h00, 1);
    drain();
    check(nreq, n0, "refused telegram executed");
    acc(1, `RFTE_REG_CFGA, {3'h0, 3'b000, 7'h01, 3'h2, 8'h31, 8'h32});
    expect_rsp(sq("41"));
    send(sq("RP1"), 8'h00, 0);
    drain();
    acc(1, `RFTE_REG_CFGA, {3'h0, 3'b000, 7'h00, 3'h2, 8'h31, 8'h32});
    // Data bytes kept above 7fh so none can read as an end character
    d = $urandom | 32'h8080_8080;
    while (sum8({sq("EL1001001"), d[31:24], d[23:16], d[15:8], d[7:0]}) == 8'h03) d++;
    {dly, fail_n} = {4'h0, 4'h2};
    expect_rsp(sq("51"));
    send({sq("EL1001001"), d[31:24], d[23:16], d[15:8], d[7:0]}, 8'h00, 1);
    drain();
    acc(0, `RFTE_REG_STAT, 32'h0000_0331);
    expect_rsp(sq("01"));
    tag_present <= 1'b1;
    drain();
    check({i_head.got[0], i_head.got[1], i_head.got[2], i_head.got[3]}, d, "data order");
    check({last_req.addr, last_req.cnt, last_req.lock_last}, {16'h0010, 6'h01, 16'h0010},
      "locked write request");
    expect_rsp(sq("01"));
    tag_new <= 1'b1;
    @(posedge ref_clk);
    tag_new <= 1'b0;
    drain();
    expect_rsp(sq("51"));
    tag_present <= 1'b0;
    drain();
    give_verdict();
  end
endmodule // rfte_engine_test
